// ===== src/io_port_block.sv
// Three programmable I/O ports with host configuration registers
`timescale 1ns/1ps
// Functional notes
// R1 - Pin input register reads the real pin level, whoever drives it.
// R2 - Bit n of every port register belongs to pin n of that port.
// R3 - Host-controlled output pins drive the stored output value bit.
// R4 - Pins driven by the logic array ignore the stored output value.
// R5 - Direction 1 means output, 0 means input; all pins start as inputs.
// R6 - Pin is output when direction bit or logic enable term is 1.
// R7 - Only the low three direction bits of the three-pin port act.
// R8 - Style bit 1 on an open-drain capable pin selects open drain.
// R9 - Style bit 1 on a slew-capable pin selects fast slew.
// R10 - First port: style bits 3..0 slew, bits 7..4 open drain.
// R11 - Logic outputs float when enable term and direction bit are 0.
// R12 - Host never sets direction on a pin used as a logic input.
// R13 - Logic sources: groups A/B, group B, and external selects.
// R14 - Eight-pin port inputs go through input macrocells; third port direct.
// R15 - Programming pins live on the second port and can be shared.
// R16 - All port configuration registers reset to zero.
// R17 - Output value register is writable and readable at any time.
// R18 - Every pin of the second port supports open drain.
// R19 - Pin driver enable is logic enable term ORed with direction bit.
// R20 - Writes captured on the write strobe; registers 8 bits, unused read 0.
module io_port_block (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic host_cs,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [io_port_pkg::ADDR_BITS-1:0] host_addr,
	input wire logic [io_port_pkg::DATA_BITS-1:0] host_wdata,
	output logic [io_port_pkg::DATA_BITS-1:0] host_rdata,
	input wire logic [7:0] first_pin_in,
	output logic [7:0] first_pin_out,
	output logic [7:0] first_pin_oe,
	output logic [3:0] first_fast_slew,
	input wire logic [7:0] second_pin_in,
	output logic [7:0] second_pin_out,
	output logic [7:0] second_pin_oe,
	input wire logic [2:0] third_pin_in,
	output logic [2:0] third_pin_out,
	output logic [2:0] third_pin_oe,
	output logic [2:0] third_fast_slew,
	input wire logic [7:0] macrocell_group_a,
	input wire logic [7:0] macrocell_group_b,
	input wire logic [7:0] first_use_group_b,
	input wire logic [7:0] first_logic_sel,
	input wire logic [7:0] first_logic_oe,
	input wire logic [7:0] second_logic_sel,
	input wire logic [7:0] second_logic_oe,
	input wire logic [2:0] external_select_outputs,
	input wire logic [2:0] third_logic_sel,
	input wire logic [2:0] third_logic_oe,
	input wire io_port_pkg::input_macrocell_mode_type input_macrocell_mode,
	input wire logic macrocell_capture_low,
	input wire logic macrocell_capture_high,
	output logic [7:0] first_logic_in,
	output logic [7:0] second_logic_in,
	output logic [2:0] third_logic_in,
	input wire logic jtag_enable,
	input wire logic jtag_data_out,
	output logic jtag_mode_sel,
	output logic jtag_clock,
	output logic jtag_data_in
);
	// Configuration registers, one set per port
	logic [7:0] first_output_value;
	logic [7:0] first_direction;
	logic [7:0] first_style;
	logic [7:0] second_output_value;
	logic [7:0] second_direction;
	logic [7:0] second_style;
	logic [2:0] third_output_value;
	logic [2:0] third_direction;
	logic [2:0] third_style;

	// Strobe capture
	logic wr_q;
	logic [io_port_pkg::ADDR_BITS-1:0] wr_addr;
	logic [io_port_pkg::DATA_BITS-1:0] wr_data;
	logic wr_take;

	// Driver results before the output flops
	logic [7:0] first_src;
	logic [7:0] next_first_out;
	logic [7:0] next_first_oe;
	logic [7:0] second_sel;
	logic [7:0] second_val;
	logic [7:0] second_oe_term;
	logic [7:0] next_second_out;
	logic [7:0] next_second_oe;
	logic [2:0] next_third_out;
	logic [2:0] next_third_oe;
	logic [io_port_pkg::DATA_BITS-1:0] next_rdata;

	// Address and data are held while the strobe is high; the write lands
	// on the trailing edge so a slow host never races its own data bus
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_q <= host_wr & host_cs;
			if (host_wr && host_cs) begin
				wr_addr <= host_addr;
				wr_data <= host_wdata;
			end
		end
	end

	assign wr_take = wr_q & ~(host_wr & host_cs); // R20

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			first_output_value <= io_port_pkg::RESET_WIDE; // R16
			first_direction <= io_port_pkg::RESET_WIDE; // R16 R5
			first_style <= io_port_pkg::RESET_WIDE; // R16
		end else if (wr_take) begin
			if (io_port_pkg::reg_hit(wr_addr, io_port_pkg::PORT_FIRST,
					io_port_pkg::REG_OUTPUT_VALUE)) begin
				first_output_value <= wr_data; // R17 R2
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_FIRST,
					io_port_pkg::REG_PIN_DIRECTION)) begin
				first_direction <= wr_data; // R2
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_FIRST,
					io_port_pkg::REG_DRIVER_STYLE)) begin
				first_style <= wr_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			second_output_value <= io_port_pkg::RESET_WIDE; // R16
			second_direction <= io_port_pkg::RESET_WIDE; // R16 R5
			second_style <= io_port_pkg::RESET_WIDE; // R16
		end else if (wr_take) begin
			if (io_port_pkg::reg_hit(wr_addr, io_port_pkg::PORT_SECOND,
					io_port_pkg::REG_OUTPUT_VALUE)) begin
				second_output_value <= wr_data; // R17 R2
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_SECOND,
					io_port_pkg::REG_PIN_DIRECTION)) begin
				second_direction <= wr_data; // R2
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_SECOND,
					io_port_pkg::REG_DRIVER_STYLE)) begin
				second_style <= wr_data;
			end
		end
	end

	// Only three pins exist, so only three bits of each register are kept
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			third_output_value <= io_port_pkg::RESET_NARROW; // R16
			third_direction <= io_port_pkg::RESET_NARROW; // R16 R5
			third_style <= io_port_pkg::RESET_NARROW; // R16
		end else if (wr_take) begin
			if (io_port_pkg::reg_hit(wr_addr, io_port_pkg::PORT_THIRD,
					io_port_pkg::REG_OUTPUT_VALUE)) begin
				third_output_value <= wr_data[2:0]; // R17 R20
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_THIRD,
					io_port_pkg::REG_PIN_DIRECTION)) begin
				third_direction <= wr_data[2:0]; // R7
			end else if (io_port_pkg::reg_hit(wr_addr,
					io_port_pkg::PORT_THIRD,
					io_port_pkg::REG_DRIVER_STYLE)) begin
				third_style <= wr_data[2:0];
			end
		end
	end

	// Read mux; pin input reads the pins themselves, not the drive values
	always_comb begin
		next_rdata = io_port_pkg::READ_UNMAPPED;
		if (io_port_pkg::reg_hit(host_addr, io_port_pkg::PORT_FIRST,
				io_port_pkg::REG_PIN_INPUT)) begin
			next_rdata = first_pin_in; // R1
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_FIRST,
				io_port_pkg::REG_OUTPUT_VALUE)) begin
			next_rdata = first_output_value; // R17
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_FIRST,
				io_port_pkg::REG_PIN_DIRECTION)) begin
			next_rdata = first_direction;
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_FIRST,
				io_port_pkg::REG_DRIVER_STYLE)) begin
			next_rdata = first_style;
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_SECOND,
				io_port_pkg::REG_PIN_INPUT)) begin
			next_rdata = second_pin_in; // R1
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_SECOND,
				io_port_pkg::REG_OUTPUT_VALUE)) begin
			next_rdata = second_output_value; // R17
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_SECOND,
				io_port_pkg::REG_PIN_DIRECTION)) begin
			next_rdata = second_direction;
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_SECOND,
				io_port_pkg::REG_DRIVER_STYLE)) begin
			next_rdata = second_style;
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_THIRD,
				io_port_pkg::REG_PIN_INPUT)) begin
			next_rdata = io_port_pkg::widen3(third_pin_in); // R1 R20
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_THIRD,
				io_port_pkg::REG_OUTPUT_VALUE)) begin
			next_rdata = io_port_pkg::widen3(third_output_value); // R20
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_THIRD,
				io_port_pkg::REG_PIN_DIRECTION)) begin
			next_rdata = io_port_pkg::widen3(third_direction); // R7
		end else if (io_port_pkg::reg_hit(host_addr,
				io_port_pkg::PORT_THIRD,
				io_port_pkg::REG_DRIVER_STYLE)) begin
			next_rdata = io_port_pkg::widen3(third_style);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			host_rdata <= io_port_pkg::READ_UNMAPPED;
		end else if (host_cs && host_rd) begin
			host_rdata <= next_rdata;
		end else begin
			host_rdata <= io_port_pkg::READ_UNMAPPED;
		end
	end

	// First port takes group A, or group B where a pin asks for it
	assign first_src = (macrocell_group_a & ~first_use_group_b)
		| (macrocell_group_b & first_use_group_b); // R13

	// Programming port borrows four pins of the second port only while
	// enabled; the rest stay ordinary I/O
	assign second_sel = jtag_enable ?
		(second_logic_sel | io_port_pkg::JTAG_OUTPUT_MASK)
		& ~io_port_pkg::JTAG_INPUT_MASK : second_logic_sel; // R15
	assign second_val = jtag_enable ?
		(macrocell_group_b & ~io_port_pkg::JTAG_OUTPUT_MASK)
		| ({8{jtag_data_out}} & io_port_pkg::JTAG_OUTPUT_MASK)
		: macrocell_group_b; // R13 R15
	assign second_oe_term = jtag_enable ?
		(second_logic_oe | io_port_pkg::JTAG_OUTPUT_MASK)
		: second_logic_oe; // R15

	port_pin_driver #(
		.PINS(io_port_pkg::WIDE_PINS)
	) first_driver (
		.output_value(first_output_value),
		.pin_direction(first_direction),
		.open_drain(first_style & io_port_pkg::FIRST_OPEN_DRAIN_MASK),
		.logic_sel(first_logic_sel),
		.logic_value(first_src),
		.logic_oe(first_logic_oe),
		.next_pin_out(next_first_out),
		.next_pin_oe(next_first_oe)
	);

	port_pin_driver #(
		.PINS(io_port_pkg::WIDE_PINS)
	) second_driver (
		.output_value(second_output_value),
		.pin_direction(second_direction),
		.open_drain(second_style & io_port_pkg::SECOND_OPEN_DRAIN_MASK),
		.logic_sel(second_sel),
		.logic_value(second_val),
		.logic_oe(second_oe_term),
		.next_pin_out(next_second_out),
		.next_pin_oe(next_second_oe)
	);

	port_pin_driver #(
		.PINS(io_port_pkg::NARROW_PINS)
	) third_driver (
		.output_value(third_output_value),
		.pin_direction(third_direction),
		.open_drain(io_port_pkg::NO_OPEN_DRAIN_NARROW),
		.logic_sel(third_logic_sel),
		.logic_value(external_select_outputs),
		.logic_oe(third_logic_oe),
		.next_pin_out(next_third_out),
		.next_pin_oe(next_third_oe)
	);

	// Pin drive is registered so every pin changes on a clean edge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			first_pin_out <= '0;
			first_pin_oe <= '0;
			second_pin_out <= '0;
			second_pin_oe <= '0;
			third_pin_out <= '0;
			third_pin_oe <= '0;
			first_fast_slew <= '0;
			third_fast_slew <= '0;
		end else begin
			first_pin_out <= next_first_out; // R3
			first_pin_oe <= next_first_oe; // R6
			second_pin_out <= next_second_out; // R3
			second_pin_oe <= next_second_oe; // R18
			third_pin_out <= next_third_out; // R13
			third_pin_oe <= next_third_oe; // R7 R11
			first_fast_slew <= first_style[3:0]
				& io_port_pkg::FIRST_SLEW_MASK[3:0]; // R9 R10
			third_fast_slew <= third_style
				& io_port_pkg::THIRD_SLEW_MASK; // R9
		end
	end

	// Input macrocells: pass through, or capture per nibble on a term
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			first_logic_in <= '0;
			second_logic_in <= '0;
		end else if (input_macrocell_mode == io_port_pkg::macrocell_pass) begin
			first_logic_in <= first_pin_in; // R14
			second_logic_in <= second_pin_in; // R14
		end else begin
			if (macrocell_capture_low) begin
				first_logic_in[3:0] <= first_pin_in[3:0]; // R14
				second_logic_in[3:0] <= second_pin_in[3:0];
			end
			if (macrocell_capture_high) begin
				first_logic_in[7:4] <= first_pin_in[7:4]; // R14
				second_logic_in[7:4] <= second_pin_in[7:4];
			end
		end
	end

	// Third port has no input macrocell; one flop only to meet output timing
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			third_logic_in <= '0;
			jtag_mode_sel <= 1'b0;
			jtag_clock <= 1'b0;
			jtag_data_in <= 1'b0;
		end else begin
			third_logic_in <= third_pin_in; // R14
			jtag_mode_sel <= jtag_enable
				& second_pin_in[io_port_pkg::JTAG_MODE_SEL_BIT]; // R15
			jtag_clock <= jtag_enable
				& second_pin_in[io_port_pkg::JTAG_CLOCK_BIT];
			jtag_data_in <= jtag_enable
				& second_pin_in[io_port_pkg::JTAG_DATA_IN_BIT];
		end
	end

endmodule : io_port_block

// ===== src/io_port_pkg.sv
// Constants, register map and helpers shared by the programmable I/O ports
package io_port_pkg;

	localparam int WIDE_PINS = 8;
	localparam int NARROW_PINS = 3;
	localparam int ADDR_BITS = 4;
	localparam int DATA_BITS = 8;

	// Host address is {port index, register index}
	localparam logic [1:0] PORT_FIRST = 2'h0;
	localparam logic [1:0] PORT_SECOND = 2'h1;
	localparam logic [1:0] PORT_THIRD = 2'h2;

	localparam logic [1:0] REG_PIN_INPUT = 2'h0;
	localparam logic [1:0] REG_OUTPUT_VALUE = 2'h1;
	localparam logic [1:0] REG_PIN_DIRECTION = 2'h2;
	localparam logic [1:0] REG_DRIVER_STYLE = 2'h3;

	localparam logic [7:0] RESET_WIDE = 8'h00;
	localparam logic [2:0] RESET_NARROW = 3'h0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Driver style bit meaning per port
	localparam logic [7:0] FIRST_SLEW_MASK = 8'h0f;
	localparam logic [7:0] FIRST_OPEN_DRAIN_MASK = 8'hf0;
	localparam logic [7:0] SECOND_OPEN_DRAIN_MASK = 8'hff;
	localparam logic [2:0] THIRD_SLEW_MASK = 3'h7;
	localparam logic [2:0] NO_OPEN_DRAIN_NARROW = 3'h0;

	// Pins of the second port shared with the programming port
	localparam int JTAG_MODE_SEL_BIT = 0;
	localparam int JTAG_CLOCK_BIT = 1;
	localparam int JTAG_DATA_IN_BIT = 2;
	localparam int JTAG_DATA_OUT_BIT = 3;
	localparam logic [7:0] JTAG_INPUT_MASK = 8'h07;
	localparam logic [7:0] JTAG_OUTPUT_MASK = 8'h08;

	typedef enum logic {
		macrocell_pass,
		macrocell_register
	} input_macrocell_mode_type;

	function automatic logic reg_hit(
		input logic [ADDR_BITS-1:0] addr,
		input logic [1:0] port,
		input logic [1:0] index
	);
		reg_hit = (addr == {port, index});
	endfunction : reg_hit

	function automatic logic [DATA_BITS-1:0] widen3(input logic [2:0] v);
		widen3 = {5'h00, v};
	endfunction : widen3

endpackage : io_port_pkg

// ===== src/port_pin_driver.sv
// Per-port output selection, enable and open-drain shaping
`timescale 1ns/1ps
module port_pin_driver #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] output_value,
	input wire logic [PINS-1:0] pin_direction,
	input wire logic [PINS-1:0] open_drain,
	input wire logic [PINS-1:0] logic_sel,
	input wire logic [PINS-1:0] logic_value,
	input wire logic [PINS-1:0] logic_oe,
	output logic [PINS-1:0] next_pin_out,
	output logic [PINS-1:0] next_pin_oe
);
	logic [PINS-1:0] value;
	logic [PINS-1:0] enable;

	always_comb begin
		// Logic-driven pins take the array value, not the stored data
		value = (logic_sel & logic_value) | (~logic_sel & output_value); // R3 R4
		// Direction bit ORed with the array enable term
		enable = pin_direction | (logic_sel & logic_oe); // R5 R6 R11 R19
		// Open drain only pulls low; a high is left to the pull-up
		next_pin_out = value & ~open_drain; // R8
		next_pin_oe = enable & ~(open_drain & value); // R8 R18
	end

endmodule : port_pin_driver

// ===== tb/io_port_block_tb_top.sv
// Self-checking bench for the I/O port block
`timescale 1ns/1ps
module io_port_block_tb_top;
	logic mclk, rst_n, host_cs, host_wr, host_rd;
	logic [io_port_pkg::ADDR_BITS-1:0] host_addr;
	logic [7:0] host_wdata, host_rdata, first_pin_in, first_pin_out;
	logic [7:0] first_pin_oe, second_pin_in, second_pin_out, second_pin_oe;
	logic [3:0] first_fast_slew;
	logic [2:0] third_pin_in, third_pin_out, third_pin_oe, third_fast_slew;
	logic [7:0] macrocell_group_a, macrocell_group_b, first_use_group_b;
	logic [7:0] first_logic_sel, first_logic_oe, second_logic_sel;
	logic [7:0] second_logic_oe, first_logic_in, second_logic_in;
	logic [2:0] external_select_outputs, third_logic_sel, third_logic_oe;
	logic [2:0] third_logic_in, ext_c, ext_c_oe;
	logic jtag_enable, jtag_data_out, jtag_mode_sel, jtag_clock, jtag_data_in;
	logic [7:0] ext_a, ext_a_oe, ext_b, ext_b_oe;
	io_port_pkg::input_macrocell_mode_type input_macrocell_mode;
	logic macrocell_capture_low, macrocell_capture_high;
	int num_errors, samples_checked, cycles;
	io_port_block i_io_port_block (.mclk, .rst_n, .host_cs, .host_wr,
		.host_rd, .host_addr, .host_wdata, .host_rdata, .first_pin_in,
		.first_pin_out, .first_pin_oe, .first_fast_slew, .second_pin_in,
		.second_pin_out, .second_pin_oe, .third_pin_in, .third_pin_out,
		.third_pin_oe, .third_fast_slew, .macrocell_group_a,
		.macrocell_group_b, .first_use_group_b, .first_logic_sel,
		.first_logic_oe, .second_logic_sel, .second_logic_oe,
		.external_select_outputs, .third_logic_sel, .third_logic_oe,
		.input_macrocell_mode, .macrocell_capture_low,
		.macrocell_capture_high, .first_logic_in,
		.second_logic_in, .third_logic_in, .jtag_enable, .jtag_data_out,
		.jtag_mode_sel, .jtag_clock, .jtag_data_in);
	pin_world #(.PINS(8)) i_pin_world_a (.pin_out(first_pin_out),
		.pin_oe(first_pin_oe), .ext_level(ext_a), .ext_oe(ext_a_oe),
		.pin_in(first_pin_in));
	pin_world #(.PINS(8)) i_pin_world_b (.pin_out(second_pin_out),
		.pin_oe(second_pin_oe), .ext_level(ext_b), .ext_oe(ext_b_oe),
		.pin_in(second_pin_in));
	pin_world #(.PINS(3)) i_pin_world_c (.pin_out(third_pin_out),
		.pin_oe(third_pin_oe), .ext_level(ext_c), .ext_oe(ext_c_oe),
		.pin_in(third_pin_in));
	task automatic give_verdict();
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [1:0] port, input logic [1:0] idx,
		input logic [7:0] d);
		@(negedge mclk);
		host_cs = 1'b1;
		host_wr = 1'b1;
		host_addr = {port, idx};
		host_wdata = d;
		@(negedge mclk);
		host_cs = 1'b0;
		host_wr = 1'b0;
		// One more edge lets the pin flops follow the register
		repeat (2) @(negedge mclk);
	endtask : wr
	task automatic rd(input logic [1:0] port, input logic [1:0] idx,
		input logic [7:0] exp, input string what);
		@(negedge mclk);
		host_cs = 1'b1;
		host_rd = 1'b1;
		host_addr = {port, idx};
		@(negedge mclk);
		check(what, host_rdata, exp);
		host_cs = 1'b0;
		host_rd = 1'b0;
	endtask : rd
	task automatic clear_all();
		for (int p = 0; p < 3; p++)
			for (int r = 1; r < 4; r++)
				wr(p[1:0], r[1:0], 8'h00);
	endtask : clear_all
	task automatic t_reset();
		for (int p = 0; p < 3; p++)
			for (int r = 1; r < 4; r++)
				rd(p[1:0], r[1:0], 8'h00, "reset value");
		check("first oe", first_pin_oe, 8'h00);
		check("third oe", {5'h00, third_pin_oe}, 8'h00);
	endtask : t_reset
	task automatic t_regs();
		for (int p = 0; p < 3; p++)
			for (int r = 1; r < 4; r++) begin
				wr(p[1:0], r[1:0], 8'ha5);
				rd(p[1:0], r[1:0], (p == 2) ? 8'h05 : 8'ha5, "rw reg");
			end
		clear_all();
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_PIN_INPUT, 8'h00);
		rd(io_port_pkg::PORT_FIRST, 2'h0, 8'hff, "pin in");
		rd(2'h3, 2'h1, 8'h00, "unmapped");
	endtask : t_regs
	task automatic t_gpio();
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_PIN_DIRECTION, 8'h0f);
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_OUTPUT_VALUE, 8'h5a);
		check("gpio oe", first_pin_oe, 8'h0f);
		check("gpio out", first_pin_out & 8'h0f, 8'h0a);
		rd(io_port_pkg::PORT_FIRST, 2'h0, 8'hfa, "gpio pins");
		clear_all();
	endtask : t_gpio
	task automatic t_drive();
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_DRIVER_STYLE, 8'hf3);
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_PIN_DIRECTION, 8'hff);
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_OUTPUT_VALUE, 8'h30);
		check("slew", {4'h0, first_fast_slew}, 8'h03);
		check("od oe", first_pin_oe, 8'hcf);
		check("od out", first_pin_out, 8'h00);
		rd(io_port_pkg::PORT_FIRST, 2'h0, 8'h30, "od pins");
		wr(io_port_pkg::PORT_SECOND, io_port_pkg::REG_DRIVER_STYLE, 8'hff);
		wr(io_port_pkg::PORT_SECOND, io_port_pkg::REG_PIN_DIRECTION, 8'hff);
		wr(io_port_pkg::PORT_SECOND, io_port_pkg::REG_OUTPUT_VALUE, 8'h0f);
		check("second oe", second_pin_oe, 8'hf0);
		wr(io_port_pkg::PORT_THIRD, io_port_pkg::REG_DRIVER_STYLE, 8'h07);
		check("third slew", {5'h00, third_fast_slew}, 8'h07);
		clear_all();
	endtask : t_drive
	task automatic t_logic();
		// Direction of logic-input pins is left clear by the host
		wr(io_port_pkg::PORT_FIRST, io_port_pkg::REG_OUTPUT_VALUE, 8'hff);
		first_logic_sel = 8'hff;
		first_logic_oe = 8'h0f;
		macrocell_group_a = 8'h96;
		macrocell_group_b = 8'h3c;
		first_use_group_b = 8'hf0;
		@(negedge mclk);
		check("logic oe", first_pin_oe, 8'h0f);
		check("logic out", first_pin_out, 8'h36);
		first_logic_oe = 8'h00;
		repeat (2) @(negedge mclk);
		check("float oe", first_pin_oe, 8'h00);
		check("macrocell pass", first_logic_in, 8'hff);
		third_logic_sel = 3'h7;
		third_logic_oe = 3'h5;
		external_select_outputs = 3'h6;
		@(negedge mclk);
		check("select out", {5'h00, third_pin_out}, 8'h06);
		check("select oe", {5'h00, third_pin_oe}, 8'h05);
		wr(io_port_pkg::PORT_THIRD, io_port_pkg::REG_PIN_DIRECTION, 8'hff);
		check("select dir oe", {5'h00, third_pin_oe}, 8'h07);
		rd(io_port_pkg::PORT_THIRD, 2'h2, 8'h07, "third dir");
		first_logic_sel = 8'h00;
		third_logic_sel = 3'h0;
		clear_all();
	endtask : t_logic
	task automatic t_jtag();
		jtag_enable = 1'b1;
		jtag_data_out = 1'b1;
		ext_b = 8'h05;
		ext_b_oe = 8'h07;
		repeat (2) @(negedge mclk);
		check("tdo pin", {6'h00, second_pin_oe[3], second_pin_out[3]}, 8'h03);
		check("jtag in", {5'h00, jtag_mode_sel, jtag_clock, jtag_data_in},
			8'h05);
		jtag_enable = 1'b0;
		ext_b_oe = 8'h00;
		repeat (2) @(negedge mclk);
		check("jtag off", {7'h00, jtag_mode_sel}, 8'h00);
	endtask : t_jtag
	task automatic t_input_cells();
		ext_a = 8'h3c;
		ext_b = 8'hc3;
		ext_c = 3'h5;
		{ext_a_oe, ext_b_oe, ext_c_oe} = '1;
		repeat (2) @(negedge mclk);
		check("first pass", first_logic_in, 8'h3c);
		check("second pass", second_logic_in, 8'hc3);
		check("third direct", {5'h00, third_logic_in}, 8'h05);
		// Register mode: each nibble follows its own capture term
		input_macrocell_mode = io_port_pkg::macrocell_register;
		macrocell_capture_low = 1'b1;
		ext_a = 8'h5a;
		ext_b = 8'ha5;
		@(negedge mclk);
		check("first low", first_logic_in, 8'h3a);
		check("second low", second_logic_in, 8'hc5);
		macrocell_capture_low = 1'b0;
		macrocell_capture_high = 1'b1;
		{ext_a, ext_b} = '0;
		@(negedge mclk);
		check("first high", first_logic_in, 8'h0a);
		check("second high", second_logic_in, 8'h05);
		macrocell_capture_high = 1'b0;
		input_macrocell_mode = io_port_pkg::macrocell_pass;
		{ext_a_oe, ext_b_oe, ext_c_oe} = '0;
		macrocell_group_b = 8'h3c;
		second_logic_sel = 8'hf0;
		second_logic_oe = 8'hf0;
		@(negedge mclk);
		check("second logic out", second_pin_out, 8'h30);
		check("second logic oe", second_pin_oe, 8'hf0);
		{second_logic_sel, second_logic_oe} = '0;
	endtask : t_input_cells
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		{rst_n, host_cs, host_wr, host_rd, jtag_enable, jtag_data_out} = '0;
		{host_addr, host_wdata, macrocell_group_a, macrocell_group_b} = '0;
		{first_use_group_b, first_logic_sel, first_logic_oe} = '0;
		{second_logic_sel, second_logic_oe, external_select_outputs} = '0;
		{third_logic_sel, third_logic_oe, ext_a, ext_a_oe} = '0;
		{ext_b, ext_b_oe, ext_c, ext_c_oe} = '0;
		{macrocell_capture_low, macrocell_capture_high} = '0;
		input_macrocell_mode = io_port_pkg::macrocell_pass;
		{num_errors, samples_checked, cycles} = '0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		t_reset();
		t_regs();
		t_gpio();
		t_drive();
		t_logic();
		t_jtag();
		t_input_cells();
		give_verdict();
	end
endmodule : io_port_block_tb_top
bind io_port_block io_port_monitor i_io_port_monitor (.mclk, .rst_n,
	.host_cs, .host_rd, .host_addr, .host_rdata, .first_pin_in,
	.first_pin_out, .first_pin_oe, .macrocell_group_a, .first_use_group_b,
	.first_logic_sel, .first_logic_oe, .second_pin_out, .second_pin_oe,
	.third_pin_in, .third_logic_in, .jtag_enable, .jtag_data_out);

// ===== tb/io_port_monitor.sv
// Port-level assertions for the I/O port block
`timescale 1ns/1ps
module io_port_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic host_cs,
	input wire logic host_rd,
	input wire logic [io_port_pkg::ADDR_BITS-1:0] host_addr,
	input wire logic [io_port_pkg::DATA_BITS-1:0] host_rdata,
	input wire logic [7:0] first_pin_in,
	input wire logic [7:0] first_pin_out,
	input wire logic [7:0] first_pin_oe,
	input wire logic [7:0] macrocell_group_a,
	input wire logic [7:0] first_use_group_b,
	input wire logic [7:0] first_logic_sel,
	input wire logic [7:0] first_logic_oe,
	input wire logic [7:0] second_pin_out,
	input wire logic [7:0] second_pin_oe,
	input wire logic [2:0] third_pin_in,
	input wire logic [2:0] third_logic_in,
	input wire logic jtag_enable,
	input wire logic jtag_data_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [7:0] forced_en;
	logic [7:0] from_a;
	// Low nibble only: the upper pins may be open drain
	assign forced_en = first_logic_sel & first_logic_oe & 8'h0f;
	assign from_a = first_logic_sel & ~first_use_group_b & 8'h0f;
	sequence read_req;
		host_cs && host_rd;
	endsequence
	sequence first_in_read;
		read_req ##0 host_addr == {io_port_pkg::PORT_FIRST,
			io_port_pkg::REG_PIN_INPUT} ##0 $stable(first_pin_in);
	endsequence
	reset_clear_a: assert property (disable iff (1'b0)
		!rst_n |=> first_pin_oe == 8'h00 && host_rdata == 8'h00)
		else $error("outputs not cleared by reset");
	pin_read_a: assert property (first_in_read |=>
		host_rdata == $past(first_pin_in)) else $error("pin read wrong");
	read_idle_a: assert property (!(host_cs && host_rd) |=>
		host_rdata == 8'h00) else $error("read data without read");
	unmapped_zero_a: assert property (read_req ##0
		host_addr[3:2] == 2'h3 |=> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	third_upper_a: assert property (read_req ##0
		host_addr[3:2] == io_port_pkg::PORT_THIRD |=> host_rdata[7:3] == 5'h00)
		else $error("third port upper bits set");
	logic_enable_a: assert property (|forced_en |=>
		(first_pin_oe & $past(forced_en)) == $past(forced_en))
		else $error("logic enable term ignored");
	logic_value_a: assert property (|from_a |=> ((first_pin_out ^
		$past(macrocell_group_a)) & $past(from_a)) == 8'h00)
		else $error("logic value not on pin");
	third_direct_a: assert property (third_logic_in == third_logic_in
		|=> third_logic_in == $past(third_pin_in))
		else $error("third port logic input wrong");
	jtag_out_a: assert property (jtag_enable |=> second_pin_oe[3] &&
		second_pin_out[3] == $past(jtag_data_out))
		else $error("programming output not driven");
endmodule : io_port_monitor

// ===== tb/pin_world.sv
// Pin-side world of one port: pull-ups and external drivers
`timescale 1ns/1ps
module pin_world #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] ext_level,
	input wire logic [PINS-1:0] ext_oe,
	output logic [PINS-1:0] pin_in
);
	// Released lines sit at the pull-up level; contention resolves low
	assign pin_in = (pin_oe & pin_out | ~pin_oe) & (ext_oe & ext_level | ~ext_oe);
endmodule : pin_world
